// ---- pkg/tq_pkg.sv ----
// constants shared by the transmit queue and its storage
package tq_pkg;

  localparam int unsigned TQ_WR_DATA_W = 8;
  localparam int unsigned TQ_RD_DATA_W = 4;
  localparam int unsigned TQ_WR_PTR_W = 8;
  localparam int unsigned TQ_RD_PTR_W = 9;
  localparam int unsigned TQ_MEM_DEPTH = 256;
  localparam int unsigned TQ_PACKET_BYTES = 265;

  localparam int unsigned TQ_NIB_LO_MSB = 3;
  localparam int unsigned TQ_NIB_LO_LSB = 0;
  localparam int unsigned TQ_NIB_HI_MSB = 7;
  localparam int unsigned TQ_NIB_HI_LSB = 4;
  localparam int unsigned TQ_RD_WORD_MSB = 8;
  localparam int unsigned TQ_RD_WORD_LSB = 1;
  localparam int unsigned TQ_RD_NIB_BIT = 0;

  localparam logic [TQ_WR_PTR_W-1:0] TQ_WR_PTR_RST = 8'h00;
  localparam logic [TQ_RD_PTR_W-1:0] TQ_RD_PTR_RST = 9'h000;
  localparam logic [TQ_RD_DATA_W-1:0] TQ_RD_DATA_RST = 4'h0;
  localparam logic TQ_EMPTY_RST = 1'b1;
  localparam logic TQ_FULL_RST = 1'b0;
  localparam logic TQ_DIR_RST = 1'b0;

endpackage : tq_pkg

// ---- rtl/tq_mem.sv ----
// byte-wide synchronous storage with a registered nibble read port
`timescale 1ns/1ps
module tq_mem
  import tq_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic wr_en_i,
  input wire logic [TQ_WR_PTR_W-1:0] wr_addr_i,
  input wire logic [TQ_WR_DATA_W-1:0] wr_data_i,
  input wire logic rd_en_i,
  input wire logic [TQ_WR_PTR_W-1:0] rd_addr_i,
  input wire logic rd_hi_i,
  output logic [TQ_RD_DATA_W-1:0] rd_data_o
);

  logic [TQ_WR_DATA_W-1:0] mem_r [TQ_MEM_DEPTH];
  wire logic [TQ_WR_DATA_W-1:0] word_sel;
  wire logic [TQ_RD_DATA_W-1:0] nib_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // no reset on the array so it maps to a ram
  always_ff @(posedge ref_clk_i) begin
    if (wr_en_i) begin
      mem_r[wr_addr_i] <= wr_data_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign word_sel = mem_r[rd_addr_i];
  assign nib_nxt = rd_hi_i ? word_sel[TQ_NIB_HI_MSB:TQ_NIB_HI_LSB]
                           : word_sel[TQ_NIB_LO_MSB:TQ_NIB_LO_LSB];

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_o <= TQ_RD_DATA_RST;
    end else if (rd_en_i) begin
      rd_data_o <= nib_nxt;
    end
  end

endmodule : tq_mem

// ---- rtl/tq_transmit_queue.sv ----
// byte-in, nibble-out transmit queue with gray pointers and retimed flags
`timescale 1ns/1ps
module tq_transmit_queue
  import tq_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic wr_en_i,
  input wire logic [TQ_WR_DATA_W-1:0] wr_data_i,
  output logic wr_full_o,
  input wire logic rd_en_i,
  output logic [TQ_RD_DATA_W-1:0] rd_data_o,
  output logic rd_empty_o
);

  ////////////////////////////////////////////////////////////////////////////
  // gray helpers, used for both pointer widths
  function automatic logic [TQ_RD_PTR_W-1:0] tq_gray_inc(
    input logic [TQ_RD_PTR_W-1:0] g
  );
    logic [TQ_RD_PTR_W-1:0] b;
    b = '0;
    b[TQ_RD_PTR_W-1] = g[TQ_RD_PTR_W-1];
    for (int i = TQ_RD_PTR_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    b = b + 1'b1;
    return b ^ (b >> 1);
  endfunction : tq_gray_inc

  ////////////////////////////////////////////////////////////////////////////
  logic [TQ_WR_PTR_W-1:0] wr_ptr_r;
  logic [TQ_RD_PTR_W-1:0] rd_ptr_r;
  logic dir_r;
  logic empty_hold_r;
  logic full_hold_r;

  wire logic wr_do;
  wire logic rd_do;
  wire logic [TQ_RD_PTR_W-1:0] wr_ext_inc;
  wire logic [TQ_WR_PTR_W-1:0] wr_ptr_nxt;
  wire logic [TQ_RD_PTR_W-1:0] rd_ptr_nxt;
  wire logic dir_nxt;
  wire logic [TQ_RD_PTR_W-1:0] wr_cmp_nxt;
  wire logic empty_raw_nxt;
  wire logic full_raw_nxt;
  wire logic rd_odd_nxt;
  wire logic rd_hi;

  ////////////////////////////////////////////////////////////////////////////
  // qualified strobes; flags are registered, so no same-cycle race
  assign wr_do = wr_en_i & ~wr_full_o;
  assign rd_do = rd_en_i & ~rd_empty_o;

  // write pointer stepped through the wide helper; its msb folds back
  // in, else the wrap from the last word gives a wrong code
  assign wr_ext_inc = tq_gray_inc({1'b0, wr_ptr_r});
  assign wr_ptr_nxt = wr_do ? {wr_ext_inc[TQ_RD_PTR_W-1] ^ wr_ext_inc[TQ_WR_PTR_W-1],
                               wr_ext_inc[TQ_WR_PTR_W-2:0]} : wr_ptr_r;
  assign rd_ptr_nxt = rd_do ? tq_gray_inc(rd_ptr_r) : rd_ptr_r;

  // direction tells full from empty when the pointers meet; a write
  // outweighs a read in the same cycle since it adds two nibbles
  assign dir_nxt = wr_do ? 1'b1 : (rd_do ? 1'b0 : dir_r);

  assign wr_cmp_nxt = {wr_ptr_nxt, ^wr_ptr_nxt};
  assign empty_raw_nxt = (rd_ptr_nxt == wr_cmp_nxt) & ~dir_nxt;
  // reader midway through the matching word: still full, a write would
  // overwrite its unread high nibble
  assign rd_odd_nxt = ^rd_ptr_nxt;
  assign full_raw_nxt =
    (rd_ptr_nxt[TQ_RD_WORD_MSB:TQ_RD_WORD_LSB] == wr_ptr_nxt) &
    (dir_nxt | rd_odd_nxt);

  // binary nibble index lsb is the parity of the whole gray pointer
  assign rd_hi = rd_ptr_r[TQ_RD_NIB_BIT] ^
                 ~(~^rd_ptr_r[TQ_RD_WORD_MSB:TQ_RD_WORD_LSB]);

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_r <= TQ_WR_PTR_RST;
      rd_ptr_r <= TQ_RD_PTR_RST;
      dir_r <= TQ_DIR_RST;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      dir_r <= dir_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // two flops per flag: set on the edge that fills or drains,
  // release one edge after the raw condition goes away
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      empty_hold_r <= TQ_EMPTY_RST;
      rd_empty_o <= TQ_EMPTY_RST;
      full_hold_r <= TQ_FULL_RST;
      wr_full_o <= TQ_FULL_RST;
    end else begin
      empty_hold_r <= empty_raw_nxt;
      rd_empty_o <= empty_raw_nxt | empty_hold_r;
      full_hold_r <= full_raw_nxt;
      wr_full_o <= full_raw_nxt | full_hold_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // storage; depth caps the queue at one ram of bytes
  tq_mem u_mem (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .wr_en_i(wr_do),
    .wr_addr_i(wr_ptr_r),
    .wr_data_i(wr_data_i),
    .rd_en_i(rd_do),
    .rd_addr_i(rd_ptr_r[TQ_RD_WORD_MSB:TQ_RD_WORD_LSB]),
    .rd_hi_i(rd_hi),
    .rd_data_o(rd_data_o)
  );

endmodule : tq_transmit_queue

// ---- verification/tq_reader_model.sv ----
// reader model: 0 stall, 1 every edge, 2 random
`timescale 1ns/1ps
module tq_reader_model (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [1:0] mode_i,
  output logic rd_en_o
);
  int seed = 32'hf232;
  initial rd_en_o = 1'b0;
  always @(posedge ref_clk_i) begin
    rd_en_o <= !rst_i && (mode_i[1] ? 1'($random(seed)) : mode_i[0]);
  end
endmodule : tq_reader_model

// ---- verification/tq_transmit_queue_asserts.sv ----
// port checker for the transmit queue
`timescale 1ns/1ps
module tq_transmit_queue_asserts
  import tq_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic wr_en_i,
  input wire logic wr_full_o,
  input wire logic rd_en_i,
  input wire logic [TQ_RD_DATA_W-1:0] rd_data_o,
  input wire logic rd_empty_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////
  // a write into an empty queue, with none one edge back, leaves empty only one more cycle
  sequence s_fill; rd_empty_o && wr_en_i && !$past(wr_en_i); endsequence
  sequence s_show; rd_empty_o ##1 !rd_empty_o; endsequence
  property p_show; s_fill |=> s_show; endproperty
  a_show: assert property (p_show) else $error("empty late");
  property p_rst; $fell(rst_i) |-> rd_empty_o && !wr_full_o; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  // a write one edge back may still clear empty
  property p_mt; rd_empty_o && !wr_en_i && !$past(wr_en_i) |=> rd_empty_o; endproperty
  a_mt: assert property (p_mt) else $error("empty cleared");
  property p_fl; wr_full_o && !rd_en_i && !$past(rd_en_i) |=> wr_full_o; endproperty
  a_fl: assert property (p_fl) else $error("full cleared");
  property p_fs; $rose(wr_full_o) |-> $past(wr_en_i); endproperty
  a_fs: assert property (p_fs) else $error("full no write");
  property p_es; $rose(rd_empty_o) |-> $past(rd_en_i); endproperty
  a_es: assert property (p_es) else $error("empty no read");
  property p_ex; !(rd_empty_o && wr_full_o); endproperty
  a_ex: assert property (p_ex) else $error("full and empty");
  property p_dt; $changed(rd_data_o) |-> $past(rd_en_i && !rd_empty_o); endproperty
  a_dt: assert property (p_dt) else $error("data moved");
endmodule : tq_transmit_queue_asserts
bind tq_transmit_queue tq_transmit_queue_asserts i_tq_transmit_queue_asserts (.ref_clk_i,
  .rst_i, .wr_en_i, .wr_full_o, .rd_en_i, .rd_data_o, .rd_empty_o);

// ---- verification/tq_transmit_queue_tb.sv ----
// self-checking bench for the transmit queue
`timescale 1ns/1ps
module tq_transmit_queue_tb;
  import tq_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wr_en_i = 1'b0;
  logic [7:0] wr_data_i = 8'h00;
  logic wr_full_o, rd_en_i, rd_empty_o;
  logic taken = 1'b0;
  logic [3:0] rd_data_o;
  logic [1:0] mode = 2'h0;
  logic [3:0] exp_q[$];
  int fails = 0, check_count = 0, seed = 32'hf232;
  always #5 ref_clk_i = ~ref_clk_i;
  tq_transmit_queue i_tq_transmit_queue (.ref_clk_i, .rst_i, .wr_en_i, .wr_data_i,
    .wr_full_o, .rd_en_i, .rd_data_o, .rd_empty_o);
  tq_reader_model i_tq_reader_model (.ref_clk_i, .rst_i, .mode_i(mode), .rd_en_o(rd_en_i));
  task automatic chk(string nm, logic [9:0] seen, logic [9:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic final_report;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report
  // bounded wait until every queued nibble came out
  task automatic drain;
    mode <= 2'h1;
    // empty may still stand one cycle after the last write
    @(posedge ref_clk_i);
    for (int i = 0; i < 2000; i++) begin
      @(posedge ref_clk_i);
      if (rd_empty_o === 1'b1 && !taken) return;
    end
    fails++;
    final_report();
  endtask : drain
  ////////////////////////////////////////////////////////////
  always @(posedge ref_clk_i) begin
    if (!rst_i && wr_en_i && !wr_full_o) begin
      exp_q.push_back(wr_data_i[3:0]);
      exp_q.push_back(wr_data_i[7:4]);
    end
    if (taken) chk("rd_data_o", rd_data_o, exp_q.pop_front());
    taken <= !rst_i && rd_en_i && !rd_empty_o;
  end
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    chk("rd_empty_o", rd_empty_o, 1'b1);
    // reader stalled: writes past capacity must be dropped
    repeat (300) begin
      @(posedge ref_clk_i);
      wr_en_i <= 1'b1;
      wr_data_i <= 8'($random(seed));
    end
    @(posedge ref_clk_i);
    wr_en_i <= 1'b0;
    chk("wr_full_o", wr_full_o, 1'b1);
    chk("depth", exp_q.size(), 2 * TQ_MEM_DEPTH);
    // one read leaves the reader midway; writes must still be dropped
    mode <= 2'h1;
    @(posedge ref_clk_i);
    mode <= 2'h0;
    wr_en_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    wr_en_i <= 1'b0;
    chk("wr_full_o", wr_full_o, 1'b1);
    chk("depth", exp_q.size(), 2 * TQ_MEM_DEPTH - 1);
    drain();
    for (int m = 1; m < 3; m++) begin
      mode <= 2'(m);
      repeat (1000) begin
        @(posedge ref_clk_i);
        wr_en_i <= 1'($random(seed));
        wr_data_i <= 8'($random(seed));
      end
      @(posedge ref_clk_i);
      wr_en_i <= 1'b0;
      drain();
      chk("left", exp_q.size(), 0);
    end
    final_report();
  end
endmodule : tq_transmit_queue_tb
